// file: rtl/complementary_output_stage.sv
`timescale 1ns/10ps
`default_nettype none
module complementary_output_stage
	import complementary_output_stage_pkg::*;
#(
	parameter int NUM_FAULTS = 4
) (
	input  wire logic                  clk_sys_i,   // System clock, 100 MHz.
	input  wire logic                  srst_i,      // Synchronous reset, active high.
	input  wire logic [ADDR_W-1:0]     addr_i,      // Register address.
	input  wire logic [DATA_W-1:0]     wdata_i,     // Register write data.
	input  wire logic                  wr_i,        // Write strobe.
	input  wire logic                  rd_i,        // Read strobe.
	output logic      [DATA_W-1:0]     rdata_o,     // Read data, cycle after the strobe.
	input  wire logic                  rise_src_i,  // Selected rising event source.
	input  wire logic                  fall_src_i,  // Selected falling event source.
	input  wire logic [NUM_FAULTS-1:0] fault_n_i,   // Fault sources, active low.
	output logic      [NUM_PINS-1:0]   out_o,       // Pin levels, index 0 is pin A.
	output logic      [NUM_PINS-1:0]   out_oe_o     // Pin output enables.
);

	logic                  en;
	logic                  en_prev;
	logic                  ld;
	logic [1:0]            clk_sel;
	logic                  shut;
	logic                  ars;
	logic [1:0]            ac_lvl;
	logic [1:0]            bd_lvl;
	logic [NUM_FAULTS-1:0] src_sel;
	logic [NUM_PINS-1:0]   pin_en;
	logic [NUM_PINS-1:0]   pol;
	logic                  sense_r;
	logic                  sense_f;
	logic [CNT_W-1:0]      buf_cnt  [NUM_TIMERS];
	logic [CNT_W-1:0]      work_cnt [NUM_TIMERS];
	logic [CNT_W:0]        tmr      [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] tmr_start;
	logic [NUM_TIMERS-1:0] tmr_busy;
	logic [NUM_TIMERS-1:0] tmr_done;
	logic [3:0]            div_cnt;
	logic                  tick;
	logic                  rise_prev;
	logic                  fall_prev;
	logic                  rise_det;
	logic                  fall_det;
	logic                  rise_acc;
	logic                  fall_acc;
	logic                  wave;
	logic                  wave_prev;
	logic                  act_q;
	logic                  comp_q;
	logic                  fault_now;
	logic                  ld_xfer;
	logic [NUM_PINS-1:0]   drive;
	logic [DATA_W-1:0]     next_rdata;
	logic                  wr_prim;
	logic                  wr_shut;

	// Decodes one count register address; used by the write and read paths.
	function automatic logic count_hit(input logic [ADDR_W-1:0] a, input int i);
		return a == ADDR_COUNT_BASE + ADDR_W'(i);
	endfunction

	// Divider mask for a clock select code.
	function automatic logic [3:0] div_mask(input logic [1:0] sel);
		case (sel)
			2'h0: return DIV_MASK_1;
			2'h1: return DIV_MASK_2;
			2'h2: return DIV_MASK_4;
			default: return DIV_MASK_16;
		endcase
	endfunction

	assign wr_prim = wr_i && (addr_i == ADDR_PRIMARY);
	assign wr_shut = wr_i && (addr_i == ADDR_SHUT_CTRL);

	// Primary control: enable and reference clock select.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			en      <= 1'b0;
			clk_sel <= CS_RST;
		end else if (wr_prim) begin
			en      <= wdata_i[EN_BIT];
			clk_sel <= wdata_i[CS_LSB +: 2];
		end
	end

	// Load request: a software set in the transfer cycle wins over the self-clear.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ld <= 1'b0;
		end else if (wr_prim) begin
			ld <= wdata_i[LD_BIT];
		end else if (ld_xfer) begin
			ld <= 1'b0;
		end
	end

	// Transfer fires only while enabled, on the accepted falling event.
	assign ld_xfer = en && ld && fall_acc;

	// Static configuration registers.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ars     <= 1'b0;
			ac_lvl  <= 2'h0;
			bd_lvl  <= 2'h0;
			src_sel <= '0;
			pin_en  <= PIN_RST;
			pol     <= PIN_RST;
			sense_r <= 1'b0;
			sense_f <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == ADDR_SHUT_CTRL) begin
				ars    <= wdata_i[SD_ARS_BIT];
				ac_lvl <= wdata_i[SD_AC_LSB +: 2];
				bd_lvl <= wdata_i[SD_BD_LSB +: 2];
			end
			if (addr_i == ADDR_SHUT_SRC) begin
				src_sel <= wdata_i[NUM_FAULTS-1:0];
			end
			if (addr_i == ADDR_PIN_CTRL) begin
				pin_en <= wdata_i[PIN_OE_LSB +: NUM_PINS];
				pol    <= wdata_i[PIN_POL_LSB +: NUM_PINS];
			end
			if (addr_i == ADDR_SENSE) begin
				sense_r <= wdata_i[SENSE_RISE_BIT];
				sense_f <= wdata_i[SENSE_FALL_BIT];
			end
		end
	end

	// Double-buffered counts; working copies never mix old and new values.
	generate
		for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_count
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					buf_cnt[i] <= COUNT_RST;
				end else if (wr_i && count_hit(addr_i, i)) begin
					buf_cnt[i] <= wdata_i[CNT_W-1:0];
				end
			end
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					work_cnt[i] <= COUNT_RST;
				end else if (wr_i && count_hit(addr_i, i) && !en) begin
					work_cnt[i] <= wdata_i[CNT_W-1:0];
				end else if (ld_xfer) begin
					work_cnt[i] <= buf_cnt[i];
				end
			end
		end
	endgenerate

	// Reference clock enable; the free-running divider is why a start lands anywhere in a period.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			div_cnt <= 4'h0;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end
	assign tick = (div_cnt & div_mask(clk_sel)) == div_mask(clk_sel);

	// Input history for edge detection and enable history for the start-up dead band.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rise_prev <= 1'b0;
			fall_prev <= 1'b0;
			wave_prev <= 1'b0;
			en_prev   <= 1'b0;
		end else begin
			rise_prev <= rise_src_i;
			fall_prev <= fall_src_i;
			wave_prev <= wave;
			en_prev   <= en;
		end
	end

	// Sense mode 0 is level, 1 is edge; a falling event is the source being low.
	assign rise_det = sense_r ? (rise_src_i && !rise_prev) : rise_src_i;
	assign fall_det = sense_f ? (!fall_src_i && fall_prev) : !fall_src_i;

	// Each blanking window masks the opposite event; pending phase delays block retriggers.
	assign rise_acc = en && rise_det && !tmr_busy[IDX_BLKF] && !tmr_busy[IDX_PHR] && !wave;
	assign fall_acc = en && fall_det && !tmr_busy[IDX_BLKR] && !tmr_busy[IDX_PHF] && wave;

	always_comb begin
		tmr_start           = '0;
		tmr_start[IDX_PHR]  = rise_acc;
		tmr_start[IDX_PHF]  = fall_acc;
		tmr_start[IDX_BLKR] = rise_acc;
		tmr_start[IDX_BLKF] = fall_acc;
		tmr_start[IDX_DBR]  = wave && !wave_prev;
		tmr_start[IDX_DBF]  = (!wave && wave_prev) || (en && !en_prev);
	end

	// Timers load N plus one and end on a reference tick, giving N to N plus one periods.
	generate
		for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
			always_ff @(posedge clk_sys_i) begin
				if (srst_i || !en) begin
					tmr[i] <= '0;
				end else if (tmr_start[i]) begin
					tmr[i] <= (CNT_W+1)'(work_cnt[i]) + 7'h01;
				end else if (tick && tmr_busy[i]) begin
					tmr[i] <= tmr[i] - 7'h01;
				end
			end
			assign tmr_busy[i] = tmr[i] != 7'h00;
			assign tmr_done[i] = tick && (tmr[i] == 7'h01) && !tmr_start[i];
		end
	endgenerate

	// Internal waveform after the phase delays; disable is the functional reset.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !en) begin
			wave <= 1'b0;
		end else if (tmr_done[IDX_PHR]) begin
			wave <= 1'b1;
		end else if (tmr_done[IDX_PHF]) begin
			wave <= 1'b0;
		end
	end

	// Dead band: each phase rises late and falls at once, so the two never overlap.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !en || !wave) begin
			act_q <= 1'b0;
		end else if (tmr_done[IDX_DBR]) begin
			act_q <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !en || wave) begin
			comp_q <= 1'b0;
		end else if (tmr_done[IDX_DBF]) begin
			comp_q <= 1'b1;
		end
	end

	// A and C carry the inactive phase, B and D the active one.
	assign drive = {act_q, comp_q, act_q, comp_q};

	// Shutdown flag: any set source wins over a software or automatic clear.
	assign fault_now = |(src_sel & ~fault_n_i);
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			shut <= 1'b0;
		end else if (fault_now || (wr_shut && wdata_i[SD_FORCE_BIT])) begin
			shut <= 1'b1;
		end else if (wr_shut) begin
			shut <= 1'b0;
		end else if (ars) begin
			shut <= 1'b0;
		end
	end

	// Pin drivers; a live fault acts in the same edge as the flag to save a cycle.
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
			logic [1:0] lvl;
			assign lvl = (i % 2 == 0) ? ac_lvl : bd_lvl;
			always_ff @(posedge clk_sys_i) begin
				if (srst_i || !en || !pin_en[i]) begin
					out_o[i]    <= 1'b0;
					out_oe_o[i] <= 1'b0;
				end else if (shut || fault_now) begin
					out_oe_o[i] <= lvl != LVL_HIGHZ;
					unique case (shut_level_type'(lvl))
						LVL_INACTIVE: out_o[i] <= pol[i];
						LVL_HIGHZ:    out_o[i] <= 1'b0;
						LVL_LOW:      out_o[i] <= 1'b0;
						LVL_HIGH:     out_o[i] <= 1'b1;
					endcase
				end else begin
					out_o[i]    <= drive[i] ^ pol[i];
					out_oe_o[i] <= 1'b1;
				end
			end
		end
	endgenerate

	// Read mux; unmapped addresses read zero.
	always_comb begin
		next_rdata = '0;
		case (addr_i)
			ADDR_PRIMARY:   next_rdata = {en, ld, 4'h0, clk_sel};
			ADDR_SHUT_CTRL: next_rdata = {2'h0, bd_lvl, ac_lvl, ars, shut};
			ADDR_SHUT_SRC:  next_rdata = DATA_W'(src_sel);
			ADDR_PIN_CTRL:  next_rdata = {pol, pin_en};
			ADDR_SENSE:     next_rdata = {6'h00, sense_f, sense_r};
			default: begin
				for (int i = 0; i < NUM_TIMERS; i++) begin
					if (count_hit(addr_i, i)) begin
						next_rdata = {2'h0, buf_cnt[i]};
					end
				end
			end
		endcase
	end

	// Read data stands for one cycle only, so stale values never linger on the bus.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !rd_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	property p_direct_load;
		@(posedge clk_sys_i) disable iff (srst_i)
		(wr_i && count_hit(addr_i, IDX_DBR) && !en) |=> (work_cnt[IDX_DBR] == $past(wdata_i[CNT_W-1:0]));
	endproperty
	a_direct_load: assert property (p_direct_load) else $error("direct count load missed");
	property p_buffered_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
		(en && !ld_xfer) |=> $stable(work_cnt[IDX_BLKR]) && $stable(work_cnt[IDX_PHF]);
	endproperty
	a_buffered_hold: assert property (p_buffered_hold) else $error("working count changed without transfer");
	property p_transfer_all;
		@(posedge clk_sys_i) disable iff (srst_i)
		ld_xfer |=> (work_cnt[IDX_PHR] == $past(buf_cnt[IDX_PHR])) && (work_cnt[IDX_DBF] == $past(buf_cnt[IDX_DBF]))
			&& (work_cnt[IDX_BLKF] == $past(buf_cnt[IDX_BLKF]));
	endproperty
	a_transfer_all: assert property (p_transfer_all) else $error("counts not transferred together");
	property p_ld_clear;
		@(posedge clk_sys_i) disable iff (srst_i)
		(ld_xfer && !wr_prim) |=> !ld;
	endproperty
	a_ld_clear: assert property (p_ld_clear) else $error("load request not cleared");
	property p_fault_shut;
		@(posedge clk_sys_i) disable iff (srst_i)
		(fault_now && en && pin_en[0] && ac_lvl == LVL_LOW) |=> shut && out_oe_o[0] && !out_o[0];
	endproperty
	a_fault_shut: assert property (p_fault_shut) else $error("fault did not force pin low");
	property p_force_shut;
		@(posedge clk_sys_i) disable iff (srst_i)
		(wr_shut && wdata_i[SD_FORCE_BIT]) |=> shut ##1 (!en || !pin_en[1] || bd_lvl != LVL_HIGH || out_o[1]);
	endproperty
	a_force_shut: assert property (p_force_shut) else $error("software shutdown not applied");
	property p_no_restart;
		@(posedge clk_sys_i) disable iff (srst_i)
		(shut && !ars && !wr_shut) |=> shut;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("shutdown left without software");
	property p_pin_off;
		@(posedge clk_sys_i) disable iff (srst_i)
		(!en || !pin_en[2]) |=> !out_oe_o[2];
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("disabled pin driven");
	property p_polarity;
		@(posedge clk_sys_i) disable iff (srst_i)
		(en && pin_en[3] && !shut && !fault_now) |=> out_oe_o[3] && (out_o[3] == ($past(act_q) ^ $past(pol[3])));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin D level wrong");
	property p_blank;
		@(posedge clk_sys_i) disable iff (srst_i)
		rise_acc |=> tmr_busy[IDX_BLKR] && !fall_acc;
	endproperty
	a_blank: assert property (p_blank) else $error("rising blanking not started");
	property p_timer_len;
		@(posedge clk_sys_i) disable iff (srst_i)
		(tmr_start[IDX_PHR] && work_cnt[IDX_PHR] == 6'h00 && clk_sel == 2'h0 && en) |=> ##1 (wave || !en);
	endproperty
	a_timer_len: assert property (p_timer_len) else $error("zero phase delay too long");
endmodule
`default_nettype wire

// file: rtl/complementary_output_stage_pkg.sv
`default_nettype none
package complementary_output_stage_pkg;
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 4;
	localparam int CNT_W      = 6;
	localparam int NUM_TIMERS = 6;
	localparam int NUM_PINS   = 4;

	// Register offsets.
	localparam logic [ADDR_W-1:0] ADDR_PRIMARY    = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_SHUT_CTRL  = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_SHUT_SRC   = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL   = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_SENSE      = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_COUNT_BASE = 4'h5;

	// Timer and count index, count register offset is base plus index.
	localparam int IDX_PHR  = 0;
	localparam int IDX_PHF  = 1;
	localparam int IDX_BLKR = 2;
	localparam int IDX_BLKF = 3;
	localparam int IDX_DBR  = 4;
	localparam int IDX_DBF  = 5;

	// Field positions.
	localparam int EN_BIT         = 7;
	localparam int LD_BIT         = 6;
	localparam int CS_LSB         = 0;
	localparam int SD_FORCE_BIT   = 0;
	localparam int SD_ARS_BIT     = 1;
	localparam int SD_AC_LSB      = 2;
	localparam int SD_BD_LSB      = 4;
	localparam int PIN_OE_LSB     = 0;
	localparam int PIN_POL_LSB    = 4;
	localparam int SENSE_RISE_BIT = 0;
	localparam int SENSE_FALL_BIT = 1;

	// Reset values.
	localparam logic [CNT_W-1:0] COUNT_RST = 6'h00;
	localparam logic [1:0]       CS_RST    = 2'h0;
	localparam logic [3:0]       PIN_RST   = 4'h0;

	// Reference clock divider masks, one per clock select code.
	localparam logic [3:0] DIV_MASK_1  = 4'h0;
	localparam logic [3:0] DIV_MASK_2  = 4'h1;
	localparam logic [3:0] DIV_MASK_4  = 4'h3;
	localparam logic [3:0] DIV_MASK_16 = 4'hf;

	typedef enum logic [1:0] {
		LVL_INACTIVE,
		LVL_HIGHZ,
		LVL_LOW,
		LVL_HIGH
	} shut_level_type;
endpackage
`default_nettype wire

// file: bench/power_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
	input  wire logic       clk_sys_i,   // System clock.
	input  wire logic [3:0] fault_req_i, // Bench request, a set bit pulls that fault low.
	input  wire logic [3:0] out_i,       // Levels from the output stage.
	input  wire logic [3:0] oe_i,        // Output enables from the output stage.
	output logic      [3:0] fault_n_o,   // Fault lines, active low, idle high.
	output logic      [3:0] pin_level_o  // Pin levels as the switch drivers see them.
);
	// Fault comparators answer one clock after a request; the lines idle high on pull-ups.
	initial fault_n_o = 4'hf;
	always @(posedge clk_sys_i) begin
		fault_n_o <= ~fault_req_i;
	end

	// Gate drivers hold pull-downs, so a released pin reads low and never keeps its last value.
	always_comb begin
		pin_level_o = out_i & oe_i;
	end
endmodule
`default_nettype wire

// file: bench/complementary_output_stage_tb.sv
`timescale 1ns/10ps
`default_nettype none
module complementary_output_stage_tb;
	import complementary_output_stage_pkg::*;

	logic              clk_sys_i  = 1'b0;
	logic              srst_i     = 1'b1;
	logic [ADDR_W-1:0] addr_i     = 4'h0;
	logic [DATA_W-1:0] wdata_i    = 8'h00;
	logic              wr_i       = 1'b0;
	logic              rd_i       = 1'b0;
	logic              rise_src_i = 1'b0;
	logic              fall_src_i = 1'b1;
	logic [3:0]        fault_req  = 4'h0;
	logic [DATA_W-1:0] rdata_o;
	logic [3:0]        out_o;
	logic [3:0]        out_oe_o;
	logic [3:0]        fault_n;
	logic [3:0]        pin_level;
	int                n_mismatch = 0;
	int                n_checks   = 0;
	int                ta0, tb0, ta1, tb1, ta2, tb2;
	// Six counts in index order: phase rise, phase fall, blank rise, blank fall, dead rise, dead fall.
	logic [5:0]        cnt_a [6]  = '{6'h02, 6'h01, 6'h02, 6'h02, 6'h01, 6'h01};
	// Expected pins under forced shutdown for each level code, with polarity set on A and C.
	logic [3:0]        lvl_out [4] = '{4'h5, 4'h0, 4'h0, 4'hf};
	logic [3:0]        lvl_oe  [4] = '{4'hf, 4'h0, 4'hf, 4'hf};

	always #5 clk_sys_i = ~clk_sys_i;

	complementary_output_stage #(.NUM_FAULTS(4)) i_dut (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.addr_i    (addr_i),
		.wdata_i   (wdata_i),
		.wr_i      (wr_i),
		.rd_i      (rd_i),
		.rdata_o   (rdata_o),
		.rise_src_i(rise_src_i),
		.fall_src_i(fall_src_i),
		.fault_n_i (fault_n),
		.out_o     (out_o),
		.out_oe_o  (out_oe_o)
	);

	power_stage_model i_switch (
		.clk_sys_i  (clk_sys_i),
		.fault_req_i(fault_req),
		.out_i      (out_o),
		.oe_i       (out_oe_o),
		.fault_n_o  (fault_n),
		.pin_level_o(pin_level)
	);

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// One-cycle write strobe; the block takes it at the following edge.
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are sampled just inside it.
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask

	// Pins are compared only where enabled; the model's pull-downs decide the rest.
	task automatic chk_pins(input logic [3:0] exp_out, input logic [3:0] exp_oe);
		@(posedge clk_sys_i);
		#1;
		check({4'h0, out_oe_o}, {4'h0, exp_oe});
		check({4'h0, out_o & exp_oe}, {4'h0, exp_out & exp_oe});
		check({4'h0, pin_level}, {4'h0, exp_out & exp_oe});
	endtask

	// Raise the rising source and time the fall of A and the rise of B in clocks.
	task automatic meas_rise(output int ta, output int tb);
		int i;
		ta = -1;
		tb = -1;
		@(posedge clk_sys_i);
		rise_src_i <= 1'b1;
		for (i = 1; i < 400; i++) begin
			@(posedge clk_sys_i);
			#1;
			if (ta < 0 && out_o[0] === 1'b0) ta = i;
			if (tb < 0 && out_o[1] === 1'b1) tb = i;
			if (ta >= 0 && tb >= 0) break;
		end
		check(8'(ta < 0 || tb < 0), 8'h00);
	endtask

	// Drop both sources to a falling event, wait for A to return, then let blanking run out.
	task automatic meas_fall();
		int i;
		@(posedge clk_sys_i);
		rise_src_i <= 1'b0;
		fall_src_i <= 1'b0;
		for (i = 0; i < 400 && out_o[0] !== 1'b1; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		check(8'(i >= 400), 8'h00);
		@(posedge clk_sys_i);
		fall_src_i <= 1'b1;
		idle(80);
	endtask

	// A hang is cut short well beyond the thousand or so clocks the sequence needs.
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		idle(16);
		srst_i <= 1'b0;
		for (int i = 0; i < 11; i++) rd_chk(4'(i), 8'h00);
		wr_reg(4'hc, 8'h5a);
		rd_chk(4'hc, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr_reg(ADDR_COUNT_BASE + 4'(i), {2'b00, cnt_a[i]});
			rd_chk(ADDR_COUNT_BASE + 4'(i), {2'b00, cnt_a[i]});
		end
		wr_reg(ADDR_PRIMARY, 8'h80);
		idle(20);
		chk_pins(4'h0, 4'h0);
		wr_reg(ADDR_PIN_CTRL, 8'h0f);
		idle(20);
		chk_pins(4'b0101, 4'hf);
		wr_reg(ADDR_PIN_CTRL, 8'h3f);
		idle(4);
		chk_pins(4'b0110, 4'hf);
		wr_reg(ADDR_PIN_CTRL, 8'h0f);
		idle(4);
		// Baseline waveform with counts loaded directly while the unit was disabled.
		meas_rise(ta0, tb0);
		meas_fall();
		wr_reg(ADDR_COUNT_BASE + 4'(IDX_PHR), 8'h06);
		wr_reg(ADDR_COUNT_BASE + 4'(IDX_DBR), 8'h05);
		rd_chk(ADDR_COUNT_BASE + 4'(IDX_PHR), 8'h06);
		meas_rise(ta1, tb1);
		check(8'(ta1 - ta0), 8'h00);
		check(8'((tb1 - ta1) - (tb0 - ta0)), 8'h00);
		meas_fall();
		wr_reg(ADDR_PRIMARY, 8'hc0);
		rd_chk(ADDR_PRIMARY, 8'hc0);
		meas_rise(ta1, tb1);
		meas_fall();
		rd_chk(ADDR_PRIMARY, 8'h80);
		meas_rise(ta1, tb1);
		check(8'(ta1 - ta0), 8'h04);
		check(8'((tb1 - ta1) - (tb0 - ta0)), 8'h04);
		meas_fall();
		// Divide-by-16 reference: six counts take 97 to 112 clocks against 7 at full rate.
		wr_reg(ADDR_PRIMARY, 8'h83);
		meas_rise(ta2, tb2);
		check(8'(ta2 - ta1 >= 90 && ta2 - ta1 <= 105), 8'h01);
		meas_fall();
		wr_reg(ADDR_PRIMARY, 8'h80);
		// Faults: an unselected low fault is ignored, a selected one shuts down.
		wr_reg(ADDR_SHUT_SRC, 8'h02);
		wr_reg(ADDR_SHUT_CTRL, 8'h38);
		@(posedge clk_sys_i);
		fault_req <= 4'h1;
		idle(4);
		rd_chk(ADDR_SHUT_CTRL, 8'h38);
		@(posedge clk_sys_i);
		fault_req <= 4'h2;
		idle(3);
		chk_pins(4'b1010, 4'hf);
		rd_chk(ADDR_SHUT_CTRL, 8'h39);
		@(posedge clk_sys_i);
		fault_req <= 4'h0;
		idle(10);
		chk_pins(4'b1010, 4'hf);
		wr_reg(ADDR_SHUT_CTRL, 8'h38);
		rd_chk(ADDR_SHUT_CTRL, 8'h38);
		wr_reg(ADDR_SHUT_CTRL, 8'h3a);
		@(posedge clk_sys_i);
		fault_req <= 4'h2;
		idle(3);
		rd_chk(ADDR_SHUT_CTRL, 8'h3b);
		@(posedge clk_sys_i);
		fault_req <= 4'h0;
		idle(4);
		rd_chk(ADDR_SHUT_CTRL, 8'h3a);
		// Software force through every override level on both pairs.
		wr_reg(ADDR_PIN_CTRL, 8'h5f);
		for (int l = 0; l < 4; l++) begin
			wr_reg(ADDR_SHUT_CTRL, 8'(l * 16 + l * 4 + 1));
			idle(2);
			chk_pins(lvl_out[l], lvl_oe[l]);
		end
		wr_reg(ADDR_SHUT_CTRL, 8'h00);
		wr_reg(ADDR_PRIMARY, 8'h00);
		idle(2);
		chk_pins(4'h0, 4'h0);
		// Edge sense with no rising phase delay; a rising source held high must not retrigger after the fall.
		wr_reg(ADDR_PIN_CTRL, 8'h0f);
		wr_reg(ADDR_COUNT_BASE + 4'(IDX_PHR), 8'h00);
		wr_reg(ADDR_SENSE, 8'h03);
		rd_chk(ADDR_SENSE, 8'h03);
		wr_reg(ADDR_PRIMARY, 8'h80);
		idle(8);
		meas_rise(ta2, tb2);
		check(8'(ta0 - ta2), 8'h02);
		@(posedge clk_sys_i);
		fall_src_i <= 1'b0;
		idle(40);
		chk_pins(4'b0101, 4'hf);
		tally_and_finish();
	end
endmodule
`default_nettype wire
